// ===== design/padc_pkg.sv
// Package of constants for the pipelined converter readout block
package padc_pkg;
    localparam int          DATA_W          = 14;
    localparam int          ADDR_W          = 2;
    // Register select codes
    localparam logic [1:0]  SEL_RESULT      = 2'h0;
    localparam logic [1:0]  SEL_GAIN        = 2'h1;
    localparam logic [1:0]  SEL_OFFSET      = 2'h2;
    localparam logic [1:0]  SEL_CONTROL     = 2'h3;
    // Control register field positions, then gain and offset register widths
    localparam int          CTL_PWD_BIT     = 13;
    localparam int          CTL_REF_BIT     = 12;
    localparam int          CTL_FMT_BIT     = 11;
    localparam int          CTL_TM_LSB      = 8;
    localparam int          CTL_OFFDIS_BIT  = 7;
    localparam int          GAIN_W          = 3;
    localparam int          OFFSET_W        = 8;
    // Reset values
    localparam logic [13:0] CTL_RESET       = 14'h0000;
    localparam logic [2:0]  GAIN_RESET      = 3'h0;
    localparam logic [7:0]  OFFSET_RESET    = 8'h00;
    // Latency in half cycles: 9.5 cycles
    localparam int          LATENCY_HALF    = 19;
    localparam int          LATENCY_FULL    = LATENCY_HALF / 2;
    localparam logic [13:0] MID_SCALE       = 14'h2000;
endpackage

// ===== design/padc_readout.sv
// Readout logic of a pipelined 14-bit converter with a parallel register port
`timescale 1ns/1ps

module padc_readout #(
    parameter int LATENCY_CYC = padc_pkg::LATENCY_FULL
) (
    // Clock and reset
    input  wire logic                        clk,
    input  wire logic                        rstn,
    input  wire logic                        clk_en,
    // Raw sample from the converter core, offset binary
    input  wire logic [padc_pkg::DATA_W-1:0] core_sample,
    // Configuration load from the write port
    input  wire logic                        cfg_we,
    input  wire logic [padc_pkg::ADDR_W-1:0] cfg_addr,
    input  wire logic [padc_pkg::DATA_W-1:0] cfg_wdata,
    // Host read pins
    input  wire logic                        oe_n,
    input  wire logic [padc_pkg::ADDR_W-1:0] reg_sel,
    output logic      [padc_pkg::DATA_W-1:0] data_out,
    output logic      [padc_pkg::DATA_W-1:0] data_oe,
    // Analog settings
    output logic      [2:0]                  gain_code,
    output logic                             power_down
);
    import padc_pkg::*;

    // Result and read registers take two rising edges, so the shift chain is one shorter
    localparam int PIPE_D = LATENCY_CYC - 1;

    if (LATENCY_CYC < 2) begin : g_bad_latency
        $error("LATENCY_CYC must be at least 2");
    end

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    // Select bits cross one by one; the host holds them steady while reading,
    // so a skewed code can only last a single cycle
    logic              oe_n_s1_ff;
    logic              oe_n_s2_ff;
    logic [1:0]        sel_s1_ff;
    logic [1:0]        sel_s2_ff;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            oe_n_s1_ff <= 1'b1;
            sel_s1_ff  <= 2'h0;
            sel_s2_ff  <= 2'h0;
            oe_n_s2_ff <= 1'b1;
        end else if (clk_en) begin
            oe_n_s1_ff <= oe_n;
            oe_n_s2_ff <= oe_n_s1_ff;
            sel_s1_ff  <= reg_sel;
            sel_s2_ff  <= sel_s1_ff;
        end
    end

    logic oe_n_sync;
    assign oe_n_sync = oe_n_s2_ff;

    // ----------------------------------------------------------------
    // Configuration registers
    // ----------------------------------------------------------------
    logic [13:0]       ctrl_ff;
    logic [2:0]        gain_ff;
    logic [7:0]        offset_ff;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            ctrl_ff   <= CTL_RESET;
            gain_ff   <= GAIN_RESET;
            offset_ff <= OFFSET_RESET;
        end else if (clk_en && cfg_we) begin
            case (cfg_addr)
                SEL_GAIN:    gain_ff   <= cfg_wdata[GAIN_W-1:0];
                SEL_OFFSET:  offset_ff <= cfg_wdata[OFFSET_W-1:0];
                SEL_CONTROL: ctrl_ff   <= cfg_wdata;
                default:     ;
            endcase
        end
    end

    assign gain_code  = gain_ff;
    assign power_down = ctrl_ff[CTL_PWD_BIT];

    // ----------------------------------------------------------------
    // Conversion pipeline
    // ----------------------------------------------------------------
    // Half-cycle of the 9.5 latency is the sample edge sitting mid-period;
    // here the sample is captured on the falling edge, giving 9.5 to output.
    logic [13:0]       neg_sample_ff;
    logic [13:0]       pipe_ff [PIPE_D];
    logic [13:0]       result_ff;
    logic [13:0]       nxt_result;

    always_ff @(negedge clk) begin
        if (clk_en) begin
            neg_sample_ff <= core_sample;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            for (int i = 0; i < PIPE_D; i++) begin
                pipe_ff[i] <= 14'h0000;
            end
        end else if (clk_en) begin
            pipe_ff[0] <= neg_sample_ff;
            for (int i = 1; i < PIPE_D; i++) begin
                pipe_ff[i] <= pipe_ff[i-1];
            end
        end
    end

    function automatic logic [13:0] fmt_result(input logic [13:0] raw, input logic [7:0] ofs,
                                               input logic dis, input logic twos);
        logic signed [15:0] sum;
        logic [13:0]        clip;
        sum = $signed({2'b00, raw}) + (dis ? 16'sd0 : 16'($signed(ofs)));
        if (sum < 0) begin
            clip = 14'h0000;
        end else if (sum > 16'sh3fff) begin
            clip = 14'h3fff;
        end else begin
            clip = sum[13:0];
        end
        return twos ? (clip ^ MID_SCALE) : clip;
    endfunction

    assign nxt_result = fmt_result(pipe_ff[PIPE_D-1], offset_ff, ctrl_ff[CTL_OFFDIS_BIT],
                                   ctrl_ff[CTL_FMT_BIT]);

    always_ff @(posedge clk) begin
        if (!rstn) begin
            result_ff <= 14'h0000;
        end else if (clk_en) begin
            result_ff <= nxt_result;
        end
    end

    // ----------------------------------------------------------------
    // Read mux and bus drivers
    // ----------------------------------------------------------------
    logic [13:0]       rdata_ff;
    logic [13:0]       nxt_rdata;
    logic [13:0]       oe_ff;

    always_comb begin
        case (sel_s2_ff)
            SEL_RESULT:  nxt_rdata = result_ff;
            SEL_GAIN:    nxt_rdata = {11'h000, gain_ff};
            SEL_OFFSET:  nxt_rdata = {6'h00, offset_ff};
            SEL_CONTROL: nxt_rdata = ctrl_ff;
            default:     nxt_rdata = 14'h0000;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            rdata_ff <= 14'h0000;
            oe_ff    <= 14'h0000;
        end else if (clk_en) begin
            rdata_ff <= nxt_rdata;
            oe_ff    <= oe_n_sync ? 14'h0000 : 14'h3fff;
        end
    end

    assign data_out = rdata_ff;
    assign data_oe  = oe_ff;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    a_oe_follows_pin: assert property (@(posedge clk) disable iff (!rstn)
        clk_en && $past(clk_en) && oe_n_sync |=> data_oe == 14'h0000)
        else $error("data driven while output enable high");
    a_oe_drives_low: assert property (@(posedge clk) disable iff (!rstn)
        clk_en && !oe_n_sync |=> data_oe == 14'h3fff)
        else $error("data not driven while output enable low");
    a_gain_read: assert property (@(posedge clk) disable iff (!rstn)
        clk_en && sel_s2_ff == SEL_GAIN |=> data_out == {11'h000, $past(gain_ff)})
        else $error("gain readback wrong");
    a_offset_read: assert property (@(posedge clk) disable iff (!rstn)
        clk_en && sel_s2_ff == SEL_OFFSET |=> data_out == {6'h00, $past(offset_ff)})
        else $error("offset readback wrong");
    a_ctrl_read: assert property (@(posedge clk) disable iff (!rstn)
        clk_en && sel_s2_ff == SEL_CONTROL |=> data_out == $past(ctrl_ff))
        else $error("control readback wrong");
    a_result_read: assert property (@(posedge clk) disable iff (!rstn)
        clk_en && sel_s2_ff == SEL_RESULT |=> data_out == $past(result_ff))
        else $error("result readback wrong");
    a_sel_path: assert property (@(posedge clk) disable iff (!rstn)
        clk_en [*3] ##0 reg_sel == SEL_OFFSET ##1 clk_en && $stable(reg_sel) ##1 clk_en
        |=> data_out == {6'h00, $past(offset_ff)})
        else $error("address pins do not steer readback");
    a_gain_drive: assert property (@(posedge clk) disable iff (!rstn)
        clk_en && cfg_we && cfg_addr == SEL_GAIN |=> gain_code == $past(cfg_wdata[2:0]))
        else $error("gain code not applied");
    a_freeze_hold: assert property (@(posedge clk) disable iff (!rstn)
        !clk_en |=> $stable(gain_code) && $stable(data_out) && $stable(data_oe) && $stable(result_ff))
        else $error("state moved while clock enable low");
    a_latency: assert property (@(posedge clk) disable iff (!rstn)
        clk_en [*8] |=> pipe_ff[PIPE_D-1] == $past(neg_sample_ff, PIPE_D))
        else $error("pipeline latency wrong");
    a_format: assert property (@(posedge clk) disable iff (!rstn)
        clk_en && ctrl_ff[CTL_OFFDIS_BIT] |=> result_ff == ($past(pipe_ff[PIPE_D-1])
                                               ^ ($past(ctrl_ff[CTL_FMT_BIT]) ? MID_SCALE : 14'h0000)))
        else $error("output format wrong");

    c_read_result: cover property (@(posedge clk) !oe_n_sync && sel_s2_ff == SEL_RESULT);
    c_read_ctrl: cover property (@(posedge clk) !oe_n_sync && sel_s2_ff == SEL_CONTROL);
    c_twos: cover property (@(posedge clk) ctrl_ff[CTL_FMT_BIT] && !oe_n_sync);
    c_gain_max: cover property (@(posedge clk) gain_ff == 3'h7);
    c_offset_off: cover property (@(posedge clk) ctrl_ff[CTL_OFFDIS_BIT] && !oe_n_sync);
endmodule

// ===== tb/padc_host_model.sv
// Host bus model: drives select and enable pins and resolves the shared data bus
`timescale 1ns/1ps
module padc_host_model (
    // Clock
    input  wire logic                        clk,
    // Device pins
    output logic                             oe_n,
    output logic      [padc_pkg::ADDR_W-1:0] reg_sel,
    input  wire logic [padc_pkg::DATA_W-1:0] data_out,
    input  wire logic [padc_pkg::DATA_W-1:0] data_oe,
    // Resolved bus
    output logic      [padc_pkg::DATA_W-1:0] bus
);
    import padc_pkg::*;
    // Pull-up on every bit, so a released line reads high rather than a stale value
    assign bus = (data_out & data_oe) | ~data_oe;
    initial begin
        oe_n    = 1'b1;
        reg_sel = 2'h0;
    end
    // Two sync stages and the output register lie in the path, so wait four edges
    task automatic set_pins(input logic en_n, input logic [1:0] sel);
        @(posedge clk);
        #2;
        reg_sel = sel;
        oe_n    = en_n;
        repeat (4) @(posedge clk);
        #2;
    endtask
    task automatic rd(input logic [1:0] sel, output logic [13:0] v);
        set_pins(1'b0, sel);
        v    = bus;
        oe_n = 1'b1;
    endtask
endmodule

// ===== tb/padc_readout_tb_top.sv
// Self-checking bench for the converter readout block
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin miscompares++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module padc_readout_tb_top;
    import padc_pkg::*;
    logic        clk;
    logic        rstn;
    logic        clk_en;
    logic        cfg_we;
    logic        oe_n;
    logic [1:0]  cfg_addr;
    logic [1:0]  reg_sel;
    logic [13:0] core_sample;
    logic [13:0] cfg_wdata;
    logic [13:0] data_out;
    logic [13:0] data_oe;
    logic [13:0] bus;
    logic [13:0] v;
    logic [2:0]  gain_code;
    logic        power_down;
    int          miscompares = 0;
    int          samples_checked = 0;

    padc_readout uut (.clk(clk), .rstn(rstn), .clk_en(clk_en), .core_sample(core_sample),
        .cfg_we(cfg_we), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .oe_n(oe_n),
        .reg_sel(reg_sel), .data_out(data_out), .data_oe(data_oe), .gain_code(gain_code),
        .power_down(power_down));
    padc_host_model host (.clk(clk), .oe_n(oe_n), .reg_sel(reg_sel), .data_out(data_out),
        .data_oe(data_oe), .bus(bus));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic wr(input logic [1:0] a, input logic [13:0] d);
        @(posedge clk);
        #2;
        cfg_we    = 1'b1;
        cfg_addr  = a;
        cfg_wdata = d;
        @(posedge clk);
        #2;
        cfg_we = 1'b0;
    endtask

    function automatic logic [13:0] exp_res(input logic [13:0] s, input logic [7:0] off,
                                            input logic [13:0] ctl);
        int r;
        r = ctl[7] ? int'(s) : int'(s) + int'($signed(off));
        r = (r < 0) ? 0 : ((r > 16383) ? 16383 : r);
        return 14'(r) ^ (ctl[11] ? 14'h2000 : 14'h0000);
    endfunction

    task automatic t_regs();
        for (int s = 1; s < 4; s++) begin
            host.rd(2'(s), v);
            `CHK(v, 14'h0000)
        end
        for (int g = 0; g < 8; g++) begin
            wr(SEL_GAIN, 14'(g));
            `CHK(gain_code, 3'(g))
            host.rd(SEL_GAIN, v);
            `CHK(v, 14'(g))
        end
        // A write while the clock enable is low must not land
        clk_en = 1'b0;
        wr(SEL_GAIN, 14'h0005);
        `CHK(gain_code, 3'h7)
        clk_en = 1'b1;
        wr(SEL_OFFSET, 14'h00a5);
        host.rd(SEL_OFFSET, v);
        `CHK(v, 14'h00a5)
        wr(SEL_CONTROL, 14'h2000);
        `CHK(power_down, 1'b1)
        host.rd(SEL_CONTROL, v);
        `CHK(v, 14'h2000)
        wr(SEL_CONTROL, 14'h0000);
    endtask

    task automatic t_tristate();
        host.set_pins(1'b0, SEL_CONTROL);
        `CHK(data_oe, 14'h3fff)
        `CHK(bus, 14'h0000)
        host.set_pins(1'b1, SEL_CONTROL);
        `CHK(data_oe, 14'h0000)
        `CHK(bus, 14'h3fff)
    endtask

    task automatic conv(input logic [13:0] s, input logic [7:0] off, input logic [13:0] ctl);
        wr(SEL_OFFSET, {6'h00, off});
        wr(SEL_CONTROL, ctl);
        core_sample = s;
        repeat (16) @(posedge clk);
        host.rd(SEL_RESULT, v);
        `CHK(v, exp_res(s, off, ctl))
    endtask

    task automatic t_latency();
        conv(14'h0100, 8'h00, 14'h0000);
        @(posedge clk);
        #2;
        core_sample = 14'h0200;
        // Captured at the next falling edge, the word must appear exactly 9.5 cycles later
        repeat (9) @(posedge clk);
        #2;
        `CHK(data_out, 14'h0100)
        @(posedge clk);
        #2;
        `CHK(data_out, 14'h0200)
    endtask

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        rstn        = 1'b0;
        clk_en      = 1'b1;
        cfg_we      = 1'b0;
        cfg_addr    = 2'h0;
        cfg_wdata   = 14'h0000;
        core_sample = MID_SCALE;
        repeat (16) @(posedge clk);
        #2;
        rstn = 1'b1;
        `CHK(gain_code, 3'h0)
        `CHK(data_out, 14'h0000)
        t_regs();
        t_tristate();
        conv(14'h1000, 8'h10, 14'h0000);
        conv(14'h1000, 8'h10, 14'h0800);
        conv(14'h1000, 8'h10, 14'h0080);
        conv(14'h3ff8, 8'h10, 14'h0000);
        conv(14'h0005, 8'hf0, 14'h0000);
        t_latency();
        give_verdict();
    end
endmodule
